// file: bench/core_model.sv
/* Core model. Assumes one-word instructions. */
`timescale 1ns/1ps
`default_nettype none
module core_model (input wire logic clk, rst_n, load, input wire logic [10:0] target,
  output logic [10:0] next_pc);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) next_pc <= 11'h001;
    else if (load) next_pc <= target + 11'h001;
endmodule
`default_nettype wire

// file: bench/irq_unit_properties.sv
/* Port checker. Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
module irq_unit_properties (input wire logic I_CLK, I_RST_N, i_TIMER_OVF, i_INSN_END,
  i_RET, i_CTRL_WE, o_PC_LOAD, o_IRQ_TAKEN, o_STACK_FULL,
  input wire logic [6:0] i_CTRL_WDATA, o_CTRL_RDATA, input wire logic [10:0] o_PC_VALUE);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  wire [6:0] c = o_CTRL_RDATA;
  wire ok = i_INSN_END & ~o_STACK_FULL & c[0] & c[2] & c[5];
  sequence s_go; o_IRQ_TAKEN && o_PC_LOAD && o_PC_VALUE == 11'h008; endsequence
  a_take_vector: assert property (ok |=> s_go) else $error("no entry");
  a_no_take: assert property (!ok |=> !o_IRQ_TAKEN) else $error("entry");
  a_take_clears: assert property (ok |=> !c[0] && (c[5] == $past(i_TIMER_OVF))) else $error("kept");
  a_ovf_sets: assert property (i_TIMER_OVF |=> c[5]) else $error("no flag");
  a_flag_holds: assert property (c[5] && !ok && !i_CTRL_WE |=> c[5]) else $error("lost");
  a_write_en: assert property (i_CTRL_WE && !ok && i_CTRL_WDATA[2:0] == 3'h5
    |=> c[2:0] == 3'h5) else $error("enables");
  a_one_pulse: assert property (o_IRQ_TAKEN |-> o_PC_LOAD ##1 !o_IRQ_TAKEN) else $error("long");
  a_stack_pop: assert property (o_STACK_FULL && i_RET |=> o_PC_LOAD && !o_STACK_FULL)
    else $error("no pop");
endmodule
bind timer_overflow_interrupt_unit irq_unit_properties i_chk (.I_CLK, .I_RST_N, .i_TIMER_OVF,
  .i_INSN_END, .i_RET, .i_CTRL_WE, .o_PC_LOAD, .o_IRQ_TAKEN, .o_STACK_FULL, .i_CTRL_WDATA,
  .o_CTRL_RDATA, .o_PC_VALUE);
`default_nettype wire

// file: bench/timer_overflow_interrupt_unit_test.sv
/* Unit bench. Assumes core model and checker. */
`timescale 1ns/1ps
`default_nettype none
module timer_overflow_interrupt_unit_test;
  logic clk = 0, rst_n = 0, ld, tk, fl;
  logic [5:0] rq = 0;
  logic [6:0] rd;
  logic [10:0] tg = 0, np, pv, t1;
  int n_errors = 0, checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  core_model i_core (.clk, .rst_n, .load(ld), .target(pv), .next_pc(np));
  timer_overflow_interrupt_unit i_dut (.I_CLK(clk), .I_RST_N(rst_n), .i_TIMER_OVF(rq[0]),
    .i_INSN_END(rq[1]), .i_NEXT_PC(np), .i_CALL(rq[2]), .i_CALL_TARGET(tg), .i_RET(rq[3]),
    .i_RETI(rq[4]), .i_CTRL_WE(rq[5]), .i_CTRL_WDATA(tg[6:0]), .o_PC_LOAD(ld),
    .o_PC_VALUE(pv), .o_IRQ_TAKEN(tk), .o_STACK_FULL(fl), .o_CTRL_RDATA(rd));
  task automatic close_out(int late);
    n_errors += late;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [10:0] g, logic [10:0] e);
    checks++;
    if (g !== e) n_errors++;
    if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
  endtask
  // Pulses one request; 0 ovf 1 end 2 call 3 ret 4 reti 5 write
  task automatic run(int b, logic [10:0] v, int s, logic [10:0] e);
    @(posedge clk) rq[b] <= 1;
    tg <= v;
    @(posedge clk) rq[b] <= 0;
    #1 chk(s == 0 ? 11'(rd) : s == 1 ? pv : s == 2 ? 11'(tk) : 11'(fl), e);
  endtask
  always @(posedge clk) if (++cyc == 900) close_out(1);
  initial begin
    void'($urandom(20));
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      t1 = k ? 11'($urandom) : 11'h7FF;
      run(0, 0, 0, 7'h20);
      run(2, t1, 1, t1);
      run(2, 11'($urandom), 3, 1);
      run(5, 7'h25, 0, 7'h25);
      run(1, 0, 2, 0);
      run(3, 0, 1, t1 + 11'h1);
      run(1, 0, 1, 11'h008);
      chk(11'(tk), 11'h001);
      chk(11'(ld), 11'h001);
      chk(11'(rd), 11'h004);
      run(4, 0, 1, t1 + 11'h2);
      run(0, 0, 0, 11'h024);
      run(1, 0, 2, 0);
      run(5, 11'h025, 0, 11'h025);
      run(0, 0, 2, 0);
      run(1, 0, 1, 11'h008);
      $display("test %0d done", k);
    end
    close_out(0);
  end
endmodule
`default_nettype wire

// file: rtl/irq_unit_pkg.sv
/*
  Constants for the timer overflow interrupt unit.
  Assumes a CPU core with a program counter and a two-entry return stack.
*/
package irq_unit_pkg;
  localparam int          PC_W          = 11;
  localparam logic [10:0] TIMER_VECTOR  = 11'h008;
  localparam logic [10:0] PC_RESET      = 11'h000;
  localparam int          STACK_DEPTH   = 2;
  localparam int          SP_W          = 2;
  localparam logic [1:0]  SP_EMPTY      = 2'h0;
  localparam logic [1:0]  SP_ONE        = 2'h1;
  localparam int          CTRL_W        = 7;
  localparam int          BIT_GLOBAL_EN = 0;
  localparam int          BIT_TIMER_EN  = 2;
  localparam int          BIT_PENDING   = 5;
  localparam logic [6:0]  CTRL_RESET    = 7'h00;
endpackage

// file: rtl/timer_overflow_interrupt_unit.sv
/*
  Timer overflow interrupt unit: request flag, enables, return stack and
  program counter diversion to the timer vector.
  Assumes the core pulses i_INSN_END at each instruction boundary, gives
  the next instruction address on i_NEXT_PC, and presents control register
  writes on i_CTRL_WE/i_CTRL_WDATA. All inputs are on I_CLK.
*/
// Behaviour
// - Overflow sets pending flag regardless of enables
// - Service needs global and timer enables set
// - Push next address and load vector on the same edge
// - Timer vector is address 08H, implicit call
// - Service clears pending flag and global enable
// - Requests with global disabled still recorded
// - Full stack blocks service until pop
// - Pending stays until serviced or cleared
// - Return pops saved program counter
// - Only program counter saved on entry
// - Global enable low disables every interrupt
// - Global enable bit 0, timer enable bit 2
// - Reset clears all interrupt control bits
`timescale 1ns/1ps
`default_nettype none
module timer_overflow_interrupt_unit #(
  parameter int DEPTH = irq_unit_pkg::STACK_DEPTH
) (
  input  wire logic                        I_CLK,
  input  wire logic                        I_RST_N,
  input  wire logic                        i_TIMER_OVF,
  input  wire logic                        i_INSN_END,
  input  wire logic [irq_unit_pkg::PC_W-1:0] i_NEXT_PC,
  input  wire logic                        i_CALL,
  input  wire logic [irq_unit_pkg::PC_W-1:0] i_CALL_TARGET,
  input  wire logic                        i_RET,
  input  wire logic                        i_RETI,
  input  wire logic                        i_CTRL_WE,
  input  wire logic [irq_unit_pkg::CTRL_W-1:0] i_CTRL_WDATA,
  output logic                             o_PC_LOAD,
  output logic [irq_unit_pkg::PC_W-1:0]    o_PC_VALUE,
  output logic                             o_IRQ_TAKEN,
  output logic                             o_STACK_FULL,
  output logic [irq_unit_pkg::CTRL_W-1:0]  o_CTRL_RDATA
);
  // ==========================================================
  // State
  // ==========================================================
  logic [irq_unit_pkg::CTRL_W-1:0] ctrl;
  logic [irq_unit_pkg::CTRL_W-1:0] next_ctrl;
  logic [irq_unit_pkg::PC_W-1:0]   stack [DEPTH];
  logic [irq_unit_pkg::PC_W-1:0]   next_stack [DEPTH];
  logic [irq_unit_pkg::SP_W-1:0]   sp;
  logic [irq_unit_pkg::SP_W-1:0]   next_sp;
  logic                            next_pc_load;
  logic [irq_unit_pkg::PC_W-1:0]   next_pc_value;
  logic                            next_irq_taken;
  logic                            next_stack_full;
  logic                            full;
  logic                            take;
  logic                            pop;
  logic [irq_unit_pkg::SP_W-1:0]   top;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    full = (sp == irq_unit_pkg::SP_W'(DEPTH));
    pop  = (i_RET || i_RETI) && (sp != irq_unit_pkg::SP_EMPTY);
    top  = sp - irq_unit_pkg::SP_ONE;
    // Enables and pending flag sampled only at the boundary
    take = i_INSN_END && !full
           && ctrl[irq_unit_pkg::BIT_GLOBAL_EN]
           && ctrl[irq_unit_pkg::BIT_TIMER_EN]
           && ctrl[irq_unit_pkg::BIT_PENDING];
    next_ctrl = ctrl;
    if (i_CTRL_WE) begin
      next_ctrl = i_CTRL_WDATA;
    end
    if (take) begin
      next_ctrl[irq_unit_pkg::BIT_PENDING]   = 1'b0;
      next_ctrl[irq_unit_pkg::BIT_GLOBAL_EN] = 1'b0;
    end
    if (i_TIMER_OVF) begin
      next_ctrl[irq_unit_pkg::BIT_PENDING] = 1'b1;
    end
    next_stack = stack;
    next_sp    = sp;
    next_pc_load  = 1'b0;
    next_pc_value = o_PC_VALUE;
    if (take) begin
      // Only the return address is saved; accumulator is untouched
      next_stack[sp[0]] = i_NEXT_PC;
      next_sp       = sp + irq_unit_pkg::SP_ONE;
      next_pc_load  = 1'b1;
      next_pc_value = irq_unit_pkg::TIMER_VECTOR;
    end else if (i_CALL && !full) begin
      next_stack[sp[0]] = i_NEXT_PC;
      next_sp       = sp + irq_unit_pkg::SP_ONE;
      next_pc_load  = 1'b1;
      next_pc_value = i_CALL_TARGET;
    end else if (pop) begin
      next_sp       = top;
      next_pc_load  = 1'b1;
      next_pc_value = stack[top[0]];
    end
    next_irq_taken  = take;
    next_stack_full = (next_sp == irq_unit_pkg::SP_W'(DEPTH));
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl         <= irq_unit_pkg::CTRL_RESET;
      sp           <= irq_unit_pkg::SP_EMPTY;
      o_PC_LOAD    <= 1'b0;
      o_PC_VALUE   <= irq_unit_pkg::PC_RESET;
      o_IRQ_TAKEN  <= 1'b0;
      o_STACK_FULL <= 1'b0;
      o_CTRL_RDATA <= irq_unit_pkg::CTRL_RESET;
      for (int i = 0; i < DEPTH; i++) begin
        stack[i] <= irq_unit_pkg::PC_RESET;
      end
    end else begin
      ctrl         <= next_ctrl;
      sp           <= next_sp;
      stack        <= next_stack;
      o_PC_LOAD    <= next_pc_load;
      o_PC_VALUE   <= next_pc_value;
      o_IRQ_TAKEN  <= next_irq_taken;
      o_STACK_FULL <= next_stack_full;
      o_CTRL_RDATA <= next_ctrl;
    end
  end
endmodule
`default_nettype wire
